// ### src/scp_serial_control_port.sv
`timescale 1ns/1ns
module scp_serial_control_port
    import scp_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Control port pins
    input wire logic i_cs_n,
    input wire logic i_ctl_serial_clock,
    input wire logic i_ctl_serial_in,
    output logic o_ctl_serial_out,
    output logic o_ctl_serial_out_oe,
    // Configuration seen by the transmitter
    output scp_tx_ctrl_type o_tx_ctrl,
    output scp_clk_ctrl_type o_clk_ctrl,
    output scp_audio_ctrl_type o_audio_ctrl,
    output logic o_soft_reset,
    // Block start pin
    input wire logic i_block_start_pin,
    input wire logic i_block_start_gen,
    output logic o_block_start_pin,
    output logic o_block_start_pin_oe,
    output logic o_block_start_in,
    // Line driver source selection
    input wire logic i_encoder_out,
    input wire logic i_external_encoded_in,
    output logic o_line_driver,
    // Audio frames in
    input wire logic i_frame_valid,
    input scp_frame_type i_frame,
    output logic o_frame_ready,
    // Audio frames out to the encoder
    output logic o_frame_valid,
    output scp_frame_type o_frame,
    input wire logic i_frame_ready
);

    // Pin synchronisers; stage one is read only by stage two
    logic cs_n_s1_reg;
    logic cs_n_s2_reg;
    logic sclk_s1_reg;
    logic sclk_s2_reg;
    logic sclk_s3_reg;
    logic sdi_s1_reg;
    logic sdi_s2_reg;
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic bls_s1_reg;
    logic bls_s2_reg;

    // Serial clock stages reset to the parked high level, so that the
    // release of reset shows no false edge to the port
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cs_n_s1_reg <= 1'b1;
            cs_n_s2_reg <= 1'b1;
            sclk_s1_reg <= 1'b1;
            sclk_s2_reg <= 1'b1;
            sclk_s3_reg <= 1'b1;
            sdi_s1_reg <= 1'b0;
            sdi_s2_reg <= 1'b0;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            bls_s1_reg <= 1'b0;
            bls_s2_reg <= 1'b0;
        end else begin
            cs_n_s1_reg <= i_cs_n;
            cs_n_s2_reg <= cs_n_s1_reg;
            sclk_s1_reg <= i_ctl_serial_clock;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            sdi_s1_reg <= i_ctl_serial_in;
            sdi_s2_reg <= sdi_s1_reg;
            ext_s1_reg <= i_external_encoded_in;
            ext_s2_reg <= ext_s1_reg;
            bls_s1_reg <= i_block_start_pin;
            bls_s2_reg <= bls_s1_reg;
        end
    end

    // Serial clock edges, qualified by a selected port
    // The third stage holds the settled previous level; logic reads it and
    // the second stage of each pin, never the first
    logic selected;
    logic sclk_rise;
    logic sclk_fall;
    assign selected = !cs_n_s2_reg;
    assign sclk_rise = selected && sclk_s2_reg && !sclk_s3_reg;
    assign sclk_fall = selected && !sclk_s2_reg && sclk_s3_reg;

    // Port state
    scp_phase_type phase_reg;
    scp_phase_type phase_next;
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_shift_reg;
    logic [7:0] tx_shift_reg;
    logic [5:0] addr_reg;
    logic is_read_reg;
    logic step_two_reg;

    // Registers
    scp_tx_ctrl_type tx_ctrl_reg;
    scp_clk_ctrl_type clk_ctrl_reg;
    scp_audio_ctrl_type audio_ctrl_reg;

    // Byte assembly: shift in MSB first on every rising edge
    logic [7:0] rx_byte;
    logic byte_done;
    assign rx_byte = {rx_shift_reg[6:0], sdi_s2_reg};
    assign byte_done = sclk_rise && (bit_cnt_reg == SCP_LAST_BIT);

    // Header decode of the first byte
    // Taken from the byte being completed, valid at its eighth rise
    logic hdr_read;
    logic hdr_step;
    logic [5:0] hdr_addr;
    assign hdr_read = rx_byte[SCP_HDR_DIR_BIT];
    assign hdr_step = rx_byte[SCP_HDR_STEP_BIT];
    assign hdr_addr = rx_byte[SCP_HDR_ADDR_MSB:0];

    // Address after one data byte, wraps in the six-bit space
    logic [5:0] addr_step;
    assign addr_step = addr_reg + (step_two_reg ? 6'h02 : 6'h01);

    // Read mux; the channel status area is not held here and reads zero
    function automatic logic [7:0] read_mux(input logic [5:0] a,
            input scp_tx_ctrl_type t, input scp_clk_ctrl_type c,
            input scp_audio_ctrl_type p);
        logic [7:0] d;
        d = SCP_READ_ZERO;
        case (a)
            SCP_OFS_TRANSMITTER_CONTROL: d = t;
            SCP_OFS_POWER_AND_CLOCK_CONTROL: d = {4'h0, c[3:0]};
            SCP_OFS_AUDIO_PORT_CONTROL: d = p;
            default: d = SCP_READ_ZERO;
        endcase
        return d;
    endfunction : read_mux

    // Phase sequencing through command byte, pad byte and data bytes
    // The pad byte is counted but never decoded, whatever it carries
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            SCP_PH_HEADER_CMD: begin
                if (byte_done) phase_next = SCP_PH_HEADER_PAD;
            end
            SCP_PH_HEADER_PAD: begin
                if (byte_done) phase_next = SCP_PH_DATA;
            end
            SCP_PH_DATA: phase_next = SCP_PH_DATA;
            default: phase_next = SCP_PH_HEADER_CMD;
        endcase
    end

    // Write strobe for a completed data byte
    logic wr_strobe;
    assign wr_strobe = byte_done && (phase_reg == SCP_PH_DATA)
        && !is_read_reg;

    // Shifting, header capture and address stepping
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            phase_reg <= SCP_PH_HEADER_CMD;
            bit_cnt_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            addr_reg <= 6'h00;
            is_read_reg <= 1'b0;
            step_two_reg <= 1'b0;
        end else if (!selected) begin
            // Deselect aborts any partial byte and rearms the header
            phase_reg <= SCP_PH_HEADER_CMD;
            bit_cnt_reg <= 3'h0;
        end else if (sclk_rise) begin
            phase_reg <= phase_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_shift_reg <= rx_byte;
            if (byte_done && phase_reg == SCP_PH_HEADER_CMD) begin
                is_read_reg <= hdr_read;
                step_two_reg <= hdr_step;
                addr_reg <= hdr_addr;
            end
            if (byte_done && phase_reg == SCP_PH_DATA) begin
                addr_reg <= addr_step;
            end
        end
    end

    // Output shifter: loaded on the rising edge that ends the header or
    // a data byte, so the next falling edge presents its MSB
    logic tx_load;
    logic [7:0] tx_load_data;
    assign tx_load = byte_done && is_read_reg
        && (phase_reg != SCP_PH_HEADER_CMD);
    assign tx_load_data = (phase_reg == SCP_PH_DATA)
        ? read_mux(addr_step, tx_ctrl_reg, clk_ctrl_reg, audio_ctrl_reg)
        : read_mux(addr_reg, tx_ctrl_reg, clk_ctrl_reg, audio_ctrl_reg);

    // Output bits change only on falling edges in the data phase of a
    // read; the enable stays low through the whole header
    logic drive_out;
    assign drive_out = sclk_fall && is_read_reg
        && (phase_reg == SCP_PH_DATA);

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_shift_reg <= 8'h00;
            o_ctl_serial_out <= 1'b0;
            o_ctl_serial_out_oe <= 1'b0;
        end else if (!selected) begin
            o_ctl_serial_out_oe <= 1'b0;
        end else if (tx_load) begin
            tx_shift_reg <= tx_load_data;
        end else if (drive_out) begin
            o_ctl_serial_out <= tx_shift_reg[7];
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            o_ctl_serial_out_oe <= 1'b1;
        end
    end

    // Register writes; the reserved location and unmapped ones ignore data
    // Limitation: a read burst fetches each next byte at the eighth rise of
    // the current one, so it shows the register values of that moment
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_ctrl_reg <= SCP_RST_TRANSMITTER_CONTROL;
            clk_ctrl_reg <= SCP_RST_POWER_AND_CLOCK_CONTROL;
            audio_ctrl_reg <= SCP_RST_AUDIO_PORT_CONTROL;
        end else if (wr_strobe) begin
            case (addr_reg)
                SCP_OFS_TRANSMITTER_CONTROL: tx_ctrl_reg <= rx_byte;
                SCP_OFS_POWER_AND_CLOCK_CONTROL:
                    clk_ctrl_reg <= {4'h0, rx_byte[3:0]};
                SCP_OFS_AUDIO_PORT_CONTROL: audio_ctrl_reg <= rx_byte;
                default: ;
            endcase
        end
    end

    // Configuration outputs as registered copies, one cycle behind the registers
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tx_ctrl <= SCP_RST_TRANSMITTER_CONTROL;
            o_clk_ctrl <= SCP_RST_POWER_AND_CLOCK_CONTROL;
            o_audio_ctrl <= SCP_RST_AUDIO_PORT_CONTROL;
            o_soft_reset <= 1'b0;
        end else begin
            o_tx_ctrl <= tx_ctrl_reg;
            o_clk_ctrl <= clk_ctrl_reg;
            o_audio_ctrl <= audio_ctrl_reg;
            o_soft_reset <= clk_ctrl_reg.soft_reset;
        end
    end

    // Line driver: grounded on reset, power down or forced off
    // Grounding wins over both sources, so no stray encoder bit reaches
    // the line while the transmitter is held off
    logic driver_off;
    logic driver_src;
    assign driver_off = tx_ctrl_reg.driver_ground_force
        || clk_ctrl_reg.power_down || clk_ctrl_reg.soft_reset;
    assign driver_src = tx_ctrl_reg.bypass ? ext_s2_reg
        : i_encoder_out;

    // Block start pin direction follows its control bit
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_line_driver <= 1'b0;
            o_block_start_pin <= 1'b0;
            o_block_start_pin_oe <= 1'b0;
            o_block_start_in <= 1'b0;
        end else begin
            o_line_driver <= driver_off ? 1'b0 : driver_src;
            o_block_start_pin <= i_block_start_gen;
            o_block_start_pin_oe <= tx_ctrl_reg.block_start_dir;
            o_block_start_in <= tx_ctrl_reg.block_start_dir ? 1'b0
                : bls_s2_reg;
        end
    end

    // Frame shaping: word length mask, channel pick, sharing and mute
    // Shaping follows the registers of the cycle in which a frame is taken;
    // a change of settings applies from the next frame on
    logic [23:0] wl_mask;
    assign wl_mask = (audio_ctrl_reg.word_length == SCP_WLEN_16)
        ? SCP_MASK_16
        : (audio_ctrl_reg.word_length == SCP_WLEN_18) ? SCP_MASK_18
        : (audio_ctrl_reg.word_length == SCP_WLEN_20) ? SCP_MASK_20
        : SCP_MASK_24;

    logic [23:0] picked_audio;
    logic picked_status;
    logic [23:0] shaped_a;
    logic [23:0] shaped_b;
    scp_frame_type shaped;
    assign picked_audio = tx_ctrl_reg.channel_pick ? i_frame.audio_b
        : i_frame.audio_a;
    assign picked_status = tx_ctrl_reg.channel_pick ? i_frame.status_b
        : i_frame.status_a;
    assign shaped_a = tx_ctrl_reg.mute ? 24'h000000
        : (tx_ctrl_reg.mono ? picked_audio : i_frame.audio_a) & wl_mask;
    assign shaped_b = tx_ctrl_reg.mute ? 24'h000000
        : (tx_ctrl_reg.mono ? picked_audio : i_frame.audio_b) & wl_mask;
    assign shaped.audio_a = shaped_a;
    assign shaped.audio_b = shaped_b;
    assign shaped.status_a = tx_ctrl_reg.shared_status_select
        ? picked_status : i_frame.status_a;
    assign shaped.status_b = tx_ctrl_reg.shared_status_select
        ? picked_status : i_frame.status_b;
    assign shaped.validity = tx_ctrl_reg.validity_flag;

    // Two-entry skid buffer: a stall by the encoder parks one frame in
    // the skid slot, and ready drops only once both slots are full
    logic skid_valid_reg;
    scp_frame_type skid_reg;
    logic take_in;
    logic out_free;
    assign take_in = i_frame_valid && o_frame_ready;
    assign out_free = !o_frame_valid || i_frame_ready;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_frame_valid <= 1'b0;
            o_frame <= '0;
            skid_valid_reg <= 1'b0;
            skid_reg <= '0;
            o_frame_ready <= 1'b0;
        end else begin
            o_frame_ready <= !(skid_valid_reg || (take_in && !out_free));
            if (out_free) begin
                if (skid_valid_reg) begin
                    o_frame <= skid_reg;
                    o_frame_valid <= 1'b1;
                    skid_valid_reg <= take_in;
                    skid_reg <= shaped;
                end else begin
                    o_frame <= shaped;
                    o_frame_valid <= take_in;
                end
            end else if (take_in) begin
                skid_reg <= shaped;
                skid_valid_reg <= 1'b1;
            end
        end
    end

endmodule : scp_serial_control_port

// ### src/scp_pkg.sv
package scp_pkg;

    // Register map, byte offsets in the control port address space
    localparam logic [5:0] SCP_OFS_FACTORY_RESERVED = 6'h00;
    localparam logic [5:0] SCP_OFS_TRANSMITTER_CONTROL = 6'h01;
    localparam logic [5:0] SCP_OFS_POWER_AND_CLOCK_CONTROL = 6'h02;
    localparam logic [5:0] SCP_OFS_AUDIO_PORT_CONTROL = 6'h03;

    // Header byte field positions
    localparam int SCP_HDR_DIR_BIT = 7;
    localparam int SCP_HDR_STEP_BIT = 6;
    localparam int SCP_HDR_ADDR_MSB = 5;

    // Values after reset, and the value read at unmapped locations
    localparam logic [7:0] SCP_RST_TRANSMITTER_CONTROL = 8'h00;
    localparam logic [7:0] SCP_RST_POWER_AND_CLOCK_CONTROL = 8'h03;
    localparam logic [7:0] SCP_RST_AUDIO_PORT_CONTROL = 8'h00;
    localparam logic [7:0] SCP_READ_ZERO = 8'h00;

    // Bits per byte on the control port, last bit index
    localparam logic [2:0] SCP_LAST_BIT = 3'h7;

    // Clock ratio codes
    localparam logic [1:0] SCP_RATIO_UNUSED = 2'h0;
    localparam logic [1:0] SCP_RATIO_256 = 2'h1;
    localparam logic [1:0] SCP_RATIO_384 = 2'h2;
    localparam logic [1:0] SCP_RATIO_512 = 2'h3;

    // Word length codes and the sample masks they apply
    localparam logic [1:0] SCP_WLEN_24 = 2'h0;
    localparam logic [1:0] SCP_WLEN_20 = 2'h1;
    localparam logic [1:0] SCP_WLEN_18 = 2'h2;
    localparam logic [1:0] SCP_WLEN_16 = 2'h3;
    localparam logic [23:0] SCP_MASK_24 = 24'hffffff;
    localparam logic [23:0] SCP_MASK_20 = 24'hfffff0;
    localparam logic [23:0] SCP_MASK_18 = 24'hfffffc;
    localparam logic [23:0] SCP_MASK_16 = 24'hffff00;

    typedef enum logic [1:0] {
        SCP_PH_HEADER_CMD,
        SCP_PH_HEADER_PAD,
        SCP_PH_DATA
    } scp_phase_type;

    typedef struct packed {
        logic driver_ground_force;
        logic shared_status_select;
        logic channel_pick;
        logic mono;
        logic bypass;
        logic mute;
        logic validity_flag;
        logic block_start_dir;
    } scp_tx_ctrl_type;

    typedef struct packed {
        logic [3:0] reserved;
        logic soft_reset;
        logic [1:0] clock_ratio;
        logic power_down;
    } scp_clk_ctrl_type;

    typedef struct packed {
        logic frame_polarity;
        logic sample_edge_select;
        logic data_delay;
        logic justify_select;
        logic [1:0] word_length;
        logic master_bitclk_ratio;
        logic master_mode;
    } scp_audio_ctrl_type;

    // One stereo frame slot: audio and channel status per subframe
    typedef struct packed {
        logic [23:0] audio_a;
        logic [23:0] audio_b;
        logic status_a;
        logic status_b;
        logic validity;
    } scp_frame_type;

endpackage : scp_pkg

// ### tb/scp_checker.sv
`timescale 1ns/1ns
module scp_checker
    import scp_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Watched inputs
    input wire logic i_cs_n,
    input wire logic i_encoder_out,
    input wire logic i_external_encoded_in,
    input wire logic i_frame_ready,
    // Watched outputs
    input wire logic o_ctl_serial_out_oe,
    input wire logic o_soft_reset,
    input wire logic o_block_start_pin_oe,
    input wire logic o_block_start_in,
    input wire logic o_line_driver,
    input wire logic o_frame_valid,
    input wire scp_tx_ctrl_type o_tx_ctrl,
    input wire scp_clk_ctrl_type o_clk_ctrl,
    input wire scp_audio_ctrl_type o_audio_ctrl,
    input wire scp_frame_type o_frame
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    // No cause for grounding the line driver is active
    wire run = !o_clk_ctrl.power_down && !o_tx_ctrl.driver_ground_force
        && !o_soft_reset;
    oe_idle_a: assert property (i_cs_n [*5] |-> !o_ctl_serial_out_oe)
        else $error("serial out driven while deselected");
    reset_vals_a: assert property (disable iff (1'b0) !i_rstn |->
        o_clk_ctrl == 8'h03 && o_tx_ctrl == 8'h00 && o_audio_ctrl == 8'h00)
        else $error("register copies wrong in reset");
    ground_a: assert property (!run [*3] |-> !o_line_driver)
        else $error("line driver not grounded");
    encoder_a: assert property ((run && !o_tx_ctrl.bypass
        && i_encoder_out) [*4] |-> o_line_driver)
        else $error("line driver not following encoder");
    bypass_a: assert property ((run && o_tx_ctrl.bypass
        && i_external_encoded_in) [*5] |-> o_line_driver)
        else $error("line driver not following external input");
    soft_rst_a: assert property (o_clk_ctrl.soft_reset [*3]
        |-> o_soft_reset)
        else $error("soft reset not raised");
    bls_out_a: assert property (o_tx_ctrl.block_start_dir [*3] |->
        o_block_start_pin_oe && !o_block_start_in)
        else $error("block start pin not an output");
    mute_zero_a: assert property (o_tx_ctrl.mute [*4] ##0
        $rose(o_frame_valid) |-> o_frame.audio_a == 24'h0
        && o_frame.audio_b == 24'h0)
        else $error("muted frame carries audio");
    valid_flag_a: assert property (o_tx_ctrl.validity_flag [*4] ##0
        $rose(o_frame_valid) |-> o_frame.validity)
        else $error("validity flag not sent");
    word_len_a: assert property (
        (o_audio_ctrl.word_length == 2'h3) [*4]
        ##0 $rose(o_frame_valid) |-> o_frame.audio_a[7:0] == 8'h0
        && o_frame.audio_b[7:0] == 8'h0)
        else $error("sixteen bit word not masked");
    frame_hold_a: assert property (o_frame_valid && !i_frame_ready |=>
        o_frame_valid && $stable(o_frame))
        else $error("stalled frame changed");
endmodule : scp_checker

bind scp_serial_control_port scp_checker u_chk (.i_clock, .i_rstn, .i_cs_n,
    .i_encoder_out, .i_external_encoded_in, .i_frame_ready,
    .o_ctl_serial_out_oe, .o_soft_reset, .o_block_start_pin_oe,
    .o_block_start_in, .o_line_driver, .o_frame_valid, .o_tx_ctrl,
    .o_clk_ctrl, .o_audio_ctrl, .o_frame);

// ### tb/scp_host.sv
`timescale 1ns/1ns
module scp_host (
    // Bench clock paces the serial clock
    input wire logic i_clock,
    // Control port pins, host side
    output logic o_cs_n,
    output logic o_ctl_serial_clock,
    output logic o_ctl_serial_in,
    input wire logic i_ctl_serial_out
);
    // Deselected, serial clock parked high between frames
    initial begin
        o_cs_n = 1'b1;
        o_ctl_serial_clock = 1'b1;
        o_ctl_serial_in = 1'b0;
    end
    // Low phase 5 cycles, high 3: the device answer lands well before rise
    task automatic xfer(input logic [47:0] tx, input int nb,
            output logic [47:0] rx);
        int i;
        rx = '0;
        @(posedge i_clock) #1 o_cs_n = 1'b0;
        for (i = 0; i < nb; i++) begin
            repeat (3) @(posedge i_clock);
            #1 o_ctl_serial_clock = 1'b0;
            o_ctl_serial_in = tx[47-i];
            repeat (5) @(posedge i_clock);
            #1 o_ctl_serial_clock = 1'b1;
            rx = {rx[46:0], i_ctl_serial_out};
        end
        // A short count leaves a partial byte behind the deselect
        repeat (3) @(posedge i_clock);
        #1 o_cs_n = 1'b1;
        o_ctl_serial_in = ~o_ctl_serial_in;
        repeat (8) @(posedge i_clock);
        #1;
    endtask : xfer
endmodule : scp_host

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench
    import scp_pkg::*;
;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b1;
    logic enc = 1'b1;
    logic ext = 1'b0;
    logic fi_valid = 1'b0;
    logic fo_ready = 1'b0;
    logic fi_ready, fo_valid, line, sdo, sdo_oe, bs_oe, bs_out, bs_in, srst;
    logic i_cs_n, sclk, sdi;
    scp_frame_type fi = '0;
    scp_frame_type fo;
    scp_tx_ctrl_type txc;
    scp_clk_ctrl_type ckc;
    scp_audio_ctrl_type apc;
    int failures = 0;
    int n_tests = 0;
    int k, acc;
    logic [31:0] q;
    logic [47:0] rx;
    logic [7:0] tx_tab [5] = '{8'h00, 8'h02, 8'h04, 8'h30, 8'h60};
    logic [7:0] ap_tab [5] = '{8'h00, 8'h0c, 8'h00, 8'h00, 8'h00};
    scp_frame_type ex_tab [5] = '{{24'h123456, 24'hfedcba, 3'b100},
        {24'h123400, 24'hfedc00, 3'b101}, {48'h0, 3'b100},
        {24'hfedcba, 24'hfedcba, 3'b100}, {24'h123456, 24'hfedcba, 3'b000}};
    wire sdo_line = sdo_oe ? sdo : 1'bz;

    // Clock, and a bound on the whole run
    always #2 i_clock = ~i_clock;
    initial begin
        #300000;
        failures++;
        complete_run();
    end

    scp_host u_host (.i_clock, .o_cs_n(i_cs_n), .o_ctl_serial_clock(sclk),
        .o_ctl_serial_in(sdi), .i_ctl_serial_out(sdo_line));
    scp_serial_control_port DUT (.i_clock, .i_rstn, .i_cs_n,
        .i_ctl_serial_clock(sclk), .i_ctl_serial_in(sdi),
        .o_ctl_serial_out(sdo), .o_ctl_serial_out_oe(sdo_oe), .o_tx_ctrl(txc),
        .o_clk_ctrl(ckc), .o_audio_ctrl(apc), .o_soft_reset(srst),
        .i_block_start_pin(1'b1), .i_block_start_gen(1'b1),
        .o_block_start_pin(bs_out), .o_block_start_pin_oe(bs_oe),
        .o_block_start_in(bs_in), .i_encoder_out(enc),
        .i_external_encoded_in(ext), .o_line_driver(line),
        .i_frame_valid(fi_valid), .i_frame(fi), .o_frame_ready(fi_ready),
        .o_frame_valid(fo_valid), .o_frame(fo), .i_frame_ready(fo_ready));

    task automatic tick;
        @(posedge i_clock) #1;
    endtask : tick
    task automatic check(input string what, input logic [63:0] seen,
            input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    // Header: direction, step, address, then an arbitrary pad byte
    function automatic logic [15:0] hdr(input logic r, s,
            input logic [5:0] a);
        return {r, s, a, 8'ha5};
    endfunction : hdr
    task automatic wr(input logic s, input logic [5:0] a, input int n,
            input logic [31:0] d);
        u_host.xfer({hdr(1'b0, s, a), d << (32 - 8 * n)}, 16 + 8 * n, rx);
        check("wr hiz", rx[15:0], 16'hzzzz);
    endtask : wr
    // Reads always fetch four bytes
    task automatic rd(input logic s, input logic [5:0] a);
        u_host.xfer({hdr(1'b1, s, a), 32'h0}, 48, rx);
        q = rx[31:0];
        check("hdr hiz", rx[47:32], 16'hzzzz);
    endtask : rd
    task automatic push(input scp_frame_type f);
        fi = f;
        fi_valid = 1'b1;
        for (k = 0; k < 20 && fi_ready !== 1'b1; k++) tick();
        if (fi_ready !== 1'b1) failures++;
        tick();
        fi_valid = 1'b0;
    endtask : push
    task automatic pull(input scp_frame_type e);
        for (k = 0; k < 20 && fo_valid !== 1'b1; k++) tick();
        if (fo_valid !== 1'b1) failures++;
        check("frame", fo, e);
        fo_ready = 1'b1;
        tick();
        fo_ready = 1'b0;
    endtask : pull

    // Main sequence
    initial begin
        #1 i_rstn = 1'b0;
        repeat (3) @(posedge i_clock);
        #1 i_rstn = 1'b1;
        repeat (2) tick();
        check("clk copy", ckc, 8'h03);
        check("line pd", line, 1'b0);
        rd(1'b0, 6'h00);
        check("reset regs", q, 32'h00000300);
        wr(1'b0, 6'h01, 3, 32'h5b04a7);
        rd(1'b0, 6'h00);
        check("regs", q, 32'h005b04a7);
        check("tx copy", txc, 8'h5b);
        check("ap copy", apc, 8'ha7);
        for (int c = 1; c < 4; c++) begin
            wr(1'b0, 6'h02, 1, 32'(c << 1));
            check("ratio", ckc.clock_ratio, c[1:0]);
        end
        // Wraps past 3f and 00, both ignored, landing in 01
        wr(1'b0, 6'h3f, 3, 32'hffff3c);
        rd(1'b1, 6'h01);
        check("step two", q, 32'h3ca70000);
        u_host.xfer({hdr(1'b0, 1'b0, 6'h01), 32'h0}, 20, rx);
        check("partial", txc, 8'h3c);
        wr(1'b0, 6'h01, 3, 32'h000200);
        check("line on", line, 1'b1);
        enc = 1'b0;
        repeat (2) tick();
        check("enc low", line, 1'b0);
        enc = 1'b1;
        wr(1'b0, 6'h01, 1, 32'h80);
        check("line off", line, 1'b0);
        wr(1'b0, 6'h01, 1, 32'h08);
        check("bypass lo", line, 1'b0);
        ext = 1'b1;
        repeat (5) tick();
        check("bypass hi", line, 1'b1);
        wr(1'b0, 6'h02, 1, 32'h0a);
        check("soft rst", {srst, line}, 2'b10);
        wr(1'b0, 6'h01, 2, 32'h0102);
        check("bls out", {bs_oe, bs_out, bs_in}, 3'b110);
        wr(1'b0, 6'h01, 1, 32'h00);
        check("bls in", {bs_oe, bs_in}, 2'b01);
        // Shaping per configuration, one frame each
        for (int i = 0; i < 5; i++) begin
            wr(1'b1, 6'h01, 2, {16'h0, tx_tab[i], ap_tab[i]});
            push({24'h123456, 24'hfedcba, 3'b100});
            pull(ex_tab[i]);
        end
        // Output stalled: offer until refused, then drain in order
        acc = 0;
        wr(1'b1, 6'h01, 2, 32'h0);
        while (fi_ready === 1'b1 && acc < 8) begin
            fi = {24'(acc), 24'h0, 3'b000};
            fi_valid = 1'b1;
            tick();
            acc++;
        end
        fi_valid = 1'b0;
        repeat (4) tick();
        check("accepted", {fi_ready, 4'(acc)}, 5'h02);
        for (int i = 0; i < acc; i++) begin
            pull({24'(i), 24'h0, 3'b000});
        end
        check("drained", {fi_ready, fo_valid}, 2'b10);
        complete_run();
    end
endmodule : testbench
